/* File: hw/liu_cfg_pkg.sv */
/*
 * Constants for the line interface configuration register bank: register
 * offsets, field positions, reset values and decoded mode types.
 * Assumes an 8-bit register port with a 5-bit address.
 */
package liu_cfg_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_LINE_IMPEDANCE_MATCH_CFG = 5'h03;
   localparam logic [4:0] OFS_JITTER_ATTEN_CFG = 5'h04;
   localparam logic [4:0] OFS_TX_PATH_CFG_A = 5'h05;
   localparam logic [4:0] OFS_TX_PATH_CFG_B = 5'h06;
   localparam logic [4:0] OFS_TX_PULSE_AMPLITUDE_SCALE = 5'h07;

   // ----------------------------------------------------------------
   // Writable bit masks; masked-off bits are reserved and read zero
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_TERM = 8'h3F;
   localparam logic [7:0] MASK_JA = 8'h3F;
   localparam logic [7:0] MASK_TXA = 8'h1F;
   localparam logic [7:0] MASK_TXB = 8'h3F;
   localparam logic [7:0] MASK_SCALE = 8'h3F;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_TERM = 8'h00;
   localparam logic [7:0] RST_JA = 8'h20;
   localparam logic [7:0] RST_TXA = 8'h00;
   localparam logic [7:0] RST_TXB = 8'h10;
   localparam logic [7:0] RST_SCALE = 8'h21;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POS_TX_TERM = 3;
   localparam int POS_RX_TERM = 0;
   localparam int POS_LIMIT = 5;
   localparam int POS_PLACE = 3;
   localparam int POS_DEPTH = 1;
   localparam int POS_BW = 0;
   localparam int POS_TX_OFF = 4;
   localparam int POS_POL = 3;
   localparam int POS_EDGE = 2;
   localparam int POS_MODE = 0;
   localparam int POS_DRIVER_MONITOR_DISABLE = 5;
   localparam int POS_TRI = 4;
   localparam int POS_PULSE = 0;

   // ----------------------------------------------------------------
   // Decoded mode types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {TERM_INT75, TERM_INT120, TERM_EXT, TERM_RSVD} term_type;
   typedef enum logic [1:0] {JA_UNUSED, JA_IN_TX, JA_IN_RX} ja_place_type;
   typedef enum logic [1:0] {DEPTH_128, DEPTH_64, DEPTH_32} ja_depth_type;
   typedef enum logic [1:0] {CODE_HDB3, CODE_AMI, CODE_DUAL_RAIL} tx_code_type;
   typedef enum logic [1:0] {TPL_E1_75, TPL_E1_120, TPL_USER, TPL_RSVD} template_type;

endpackage : liu_cfg_pkg

/* File: hw/liu_line_and_tx_config_regs.sv */
/*
 * Configuration register bank for the line termination, jitter attenuator
 * and transmit path of a single E1 line interface, with decoded controls.
 * Assumes a synchronous register port on clk_sys; reads answer one cycle
 * after the read strobe and the master never waits.
 */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Transmit termination code 000 internal 75, 001 internal 120, 1xx external.
// - Receive termination code 000 internal 75, 001 internal 120, 1xx external.
// - Attenuator placement 00/10 unused, 01 transmit path, 11 receive path.
// - Attenuator depth 00 gives 128 bits, 01 gives 64, 1x gives 32.
// - Bandwidth bit clear selects 6.8 Hz corner, set selects 0.9 Hz.
// - Transmit power-down bit powers transmitter off and tristates line driver.
// - Polarity bit set treats transmit data as active low.
// - Edge bit clear samples dual-rail data on falling edge, set on rising.
// - Coding mode 00 takes single-rail data through HDB3 encoding.
// - Coding mode 01 takes single-rail data through AMI encoding.
// - Coding mode 1x bypasses encoder and takes dual-rail data.
// - Monitor disable bit clear keeps failure monitor on, set turns off.
// - Tristate bit resets high and only floats the line driver.
// - Template 0000 E1 75 ohm, 0001 E1 120 ohm, 11xx user waveform.
module liu_line_and_tx_config_regs
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [liu_cfg_pkg::ADDR_W-1:0] regAddr,
   input wire logic [liu_cfg_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [liu_cfg_pkg::DATA_W-1:0] regRdData,
   output liu_cfg_pkg::term_type txTermSel,
   output liu_cfg_pkg::term_type rxTermSel,
   output logic attenLimitMode,
   output liu_cfg_pkg::ja_place_type attenPlacement,
   output liu_cfg_pkg::ja_depth_type attenDepth,
   output logic attenBandwidthLow,
   output logic txPowerDown,
   output logic lineDriverHighZ,
   output logic txDataPolarityLow,
   output logic txSampleRising,
   output liu_cfg_pkg::tx_code_type txCodingMode,
   output logic txUseDualRail,
   output logic driverMonitorEnable,
   output liu_cfg_pkg::template_type pulseTemplateSel,
   output logic [5:0] pulseScale
);
   import liu_cfg_pkg::*;

   // ----------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------

   // Both termination fields share one encoding, so one function decodes them.
   function automatic term_type decodeTerm(input logic [2:0] code);
      term_type t;
      t = TERM_RSVD;
      if (code[2])
      begin
         t = TERM_EXT;
      end
      else if (code == 3'b000)
      begin
         t = TERM_INT75;
      end
      else if (code == 3'b001)
      begin
         t = TERM_INT120;
      end
      return t;
   endfunction : decodeTerm

   // Reserved template codes decode to their own value so the shaper can hold off.
   function automatic template_type decodeTemplate(input logic [3:0] code);
      template_type t;
      t = TPL_RSVD;
      if (code[3:2] == 2'b11)
      begin
         t = TPL_USER;
      end
      else if (code == 4'b0000)
      begin
         t = TPL_E1_75;
      end
      else if (code == 4'b0001)
      begin
         t = TPL_E1_120;
      end
      return t;
   endfunction : decodeTemplate

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0] termCfg_reg;
   logic [7:0] jaCfg_reg;
   logic [7:0] txCfgA_reg;
   logic [7:0] txCfgB_reg;
   logic [7:0] scale_reg;
   logic [7:0] rdData_next;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      return a == ofs;
   endfunction : hit

   // Writes store only the defined bits; reserved bits stay zero whatever
   // software sends, which keeps reads predictable.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         termCfg_reg <= RST_TERM;
         jaCfg_reg <= RST_JA;
         txCfgA_reg <= RST_TXA;
         txCfgB_reg <= RST_TXB;
         scale_reg <= RST_SCALE;
      end
      else if (regWrite)
      begin
         if (hit(regAddr, OFS_LINE_IMPEDANCE_MATCH_CFG))
         begin
            termCfg_reg <= regWrData & MASK_TERM;
         end
         if (hit(regAddr, OFS_JITTER_ATTEN_CFG))
         begin
            jaCfg_reg <= regWrData & MASK_JA;
         end
         if (hit(regAddr, OFS_TX_PATH_CFG_A))
         begin
            txCfgA_reg <= regWrData & MASK_TXA;
         end
         if (hit(regAddr, OFS_TX_PATH_CFG_B))
         begin
            txCfgB_reg <= regWrData & MASK_TXB;
         end
         if (hit(regAddr, OFS_TX_PULSE_AMPLITUDE_SCALE))
         begin
            scale_reg <= regWrData & MASK_SCALE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------

   // Unmapped addresses read zero.
   always_comb
   begin
      rdData_next = 8'h00;
      case (regAddr)
         OFS_LINE_IMPEDANCE_MATCH_CFG: rdData_next = termCfg_reg;
         OFS_JITTER_ATTEN_CFG: rdData_next = jaCfg_reg;
         OFS_TX_PATH_CFG_A: rdData_next = txCfgA_reg;
         OFS_TX_PATH_CFG_B: rdData_next = txCfgB_reg;
         OFS_TX_PULSE_AMPLITUDE_SCALE: rdData_next = scale_reg;
         default: rdData_next = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe, zero otherwise.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         regRdData <= 8'h00;
      end
      else
      begin
         regRdData <= regRead ? rdData_next : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Decoded control outputs
   // ----------------------------------------------------------------

   // Registered once more so each output comes straight from a flip-flop;
   // controls lag the register write by one cycle.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         txTermSel <= TERM_INT75;
         rxTermSel <= TERM_INT75;
         attenLimitMode <= RST_JA[POS_LIMIT];
         attenPlacement <= JA_UNUSED;
         attenDepth <= DEPTH_128;
         attenBandwidthLow <= 1'b0;
         txPowerDown <= 1'b0;
         lineDriverHighZ <= RST_TXB[POS_TRI];
         txDataPolarityLow <= 1'b0;
         txSampleRising <= 1'b0;
         txCodingMode <= CODE_HDB3;
         txUseDualRail <= 1'b0;
         driverMonitorEnable <= 1'b1;
         pulseTemplateSel <= TPL_E1_75;
         pulseScale <= RST_SCALE[5:0];
      end
      else
      begin
         txTermSel <= decodeTerm(termCfg_reg[POS_TX_TERM +: 3]);
         rxTermSel <= decodeTerm(termCfg_reg[POS_RX_TERM +: 3]);
         attenLimitMode <= jaCfg_reg[POS_LIMIT];
         case (jaCfg_reg[POS_PLACE +: 2])
            2'b01: attenPlacement <= JA_IN_TX;
            2'b11: attenPlacement <= JA_IN_RX;
            default: attenPlacement <= JA_UNUSED;
         endcase
         case (jaCfg_reg[POS_DEPTH +: 2])
            2'b00: attenDepth <= DEPTH_128;
            2'b01: attenDepth <= DEPTH_64;
            default: attenDepth <= DEPTH_32;
         endcase
         attenBandwidthLow <= jaCfg_reg[POS_BW];
         txPowerDown <= txCfgA_reg[POS_TX_OFF];
         // Power-down also floats the driver; the tristate bit alone does not stop the path.
         lineDriverHighZ <= txCfgA_reg[POS_TX_OFF] | txCfgB_reg[POS_TRI];
         txDataPolarityLow <= txCfgA_reg[POS_POL];
         txSampleRising <= txCfgA_reg[POS_EDGE];
         case (txCfgA_reg[POS_MODE +: 2])
            2'b00: txCodingMode <= CODE_HDB3;
            2'b01: txCodingMode <= CODE_AMI;
            default: txCodingMode <= CODE_DUAL_RAIL;
         endcase
         txUseDualRail <= txCfgA_reg[POS_MODE + 1];
         driverMonitorEnable <= ~txCfgB_reg[POS_DRIVER_MONITOR_DISABLE];
         pulseTemplateSel <= decodeTemplate(txCfgB_reg[POS_PULSE +: 4]);
         pulseScale <= scale_reg[5:0];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_wrTx(logic [4:0] ofs);
      regWrite && regAddr == ofs;
   endsequence

   property p_txTerm;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_LINE_IMPEDANCE_MATCH_CFG) && regWrData[5] ##2 1'b1 |-> txTermSel == TERM_EXT;
   endproperty
   a_txTerm: assert property (p_txTerm) else $error("tx termination not external");

   property p_rxTerm;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_LINE_IMPEDANCE_MATCH_CFG) && regWrData[2:0] == 3'b001
      |-> ##2 rxTermSel == TERM_INT120;
   endproperty
   a_rxTerm: assert property (p_rxTerm) else $error("rx termination not 120 ohm");

   // Any code with the top bit set must pick the external resistors.
   property p_rxExt;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_LINE_IMPEDANCE_MATCH_CFG) && regWrData[2] |-> ##2 rxTermSel == TERM_EXT;
   endproperty
   a_rxExt: assert property (p_rxExt) else $error("rx termination not external");

   // The all-zero code is the 75 ohm internal match.
   property p_txInt75;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_LINE_IMPEDANCE_MATCH_CFG) && regWrData[5:3] == 3'b000
      |-> ##2 txTermSel == TERM_INT75;
   endproperty
   a_txInt75: assert property (p_txInt75) else $error("tx termination not 75 ohm");

   property p_place;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_JITTER_ATTEN_CFG) && regWrData[4:3] == 2'b10 |-> ##2 attenPlacement == JA_UNUSED;
   endproperty
   a_place: assert property (p_place) else $error("attenuator placement wrong");

   property p_depth;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_JITTER_ATTEN_CFG) && regWrData[2:1] == 2'b01 |-> ##2 attenDepth == DEPTH_64;
   endproperty
   a_depth: assert property (p_depth) else $error("attenuator depth wrong");

   property p_bw;
      @(posedge clk_sys) disable iff (!resetn)
      ##1 attenBandwidthLow == $past(jaCfg_reg[POS_BW]);
   endproperty
   a_bw: assert property (p_bw) else $error("bandwidth select wrong");

   property p_off;
      @(posedge clk_sys) disable iff (!resetn)
      txPowerDown |-> lineDriverHighZ;
   endproperty
   a_off: assert property (p_off) else $error("driver active while powered down");

   property p_pol;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_TX_PATH_CFG_A) |-> ##2 txDataPolarityLow == $past(regWrData[3], 2);
   endproperty
   a_pol: assert property (p_pol) else $error("polarity not applied");

   property p_edge;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_TX_PATH_CFG_A) |-> ##2 txSampleRising == $past(regWrData[2], 2);
   endproperty
   a_edge: assert property (p_edge) else $error("sample edge not applied");

   property p_dual;
      @(posedge clk_sys) disable iff (!resetn)
      txUseDualRail == (txCodingMode == CODE_DUAL_RAIL);
   endproperty
   a_dual: assert property (p_dual) else $error("dual rail mismatch");

   // Both single-rail codes are checked, since they differ only in one bit.
   property p_hdb3;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_TX_PATH_CFG_A) && regWrData[1:0] == 2'b00 |-> ##2 txCodingMode == CODE_HDB3;
   endproperty
   a_hdb3: assert property (p_hdb3) else $error("hdb3 coding not selected");

   property p_ami;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_TX_PATH_CFG_A) && regWrData[1:0] == 2'b01 |-> ##2 txCodingMode == CODE_AMI;
   endproperty
   a_ami: assert property (p_ami) else $error("ami coding not selected");

   // The tristate bit alone must float the driver.
   property p_tri;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_TX_PATH_CFG_B) && regWrData[4] |-> ##2 lineDriverHighZ;
   endproperty
   a_tri: assert property (p_tri) else $error("driver not floated");

   property p_mon;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_TX_PATH_CFG_B) && regWrData[5] |-> ##2 !driverMonitorEnable;
   endproperty
   a_mon: assert property (p_mon) else $error("monitor not disabled");

   property p_tpl;
      @(posedge clk_sys) disable iff (!resetn)
      s_wrTx(OFS_TX_PATH_CFG_B) && regWrData[3:2] == 2'b11 |-> ##2 pulseTemplateSel == TPL_USER;
   endproperty
   a_tpl: assert property (p_tpl) else $error("user template not selected");

   property p_rst;
      @(posedge clk_sys) $rose(resetn) |-> lineDriverHighZ && attenLimitMode;
   endproperty
   a_rst: assert property (p_rst) else $error("reset defaults wrong");

endmodule : liu_line_and_tx_config_regs

/* File: testbench/liu_line_and_tx_config_regs_bench.sv */
/*
 * Self-checking bench for the line configuration register bank.
 * Assumes reads answer one cycle after the strobe and decoded outputs
 * follow a write one cycle after the register itself.
 */
`timescale 1ns/1ps

module liu_line_and_tx_config_regs_bench;
   import liu_cfg_pkg::*;

   // ---------------------------------------------------------------
   // Signals and shadow copies of the registers
   // ---------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWrData = '0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [DATA_W-1:0] regRdData;
   term_type txTermSel, rxTermSel;
   ja_place_type attenPlacement;
   ja_depth_type attenDepth;
   tx_code_type txCodingMode;
   template_type pulseTemplateSel;
   logic attenLimitMode, attenBandwidthLow, txPowerDown, lineDriverHighZ;
   logic txDataPolarityLow, txSampleRising, txUseDualRail, driverMonitorEnable;
   logic [5:0] pulseScale;
   logic [7:0] mTerm, mJa, mTxa, mTxb, mScale;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   liu_line_and_tx_config_regs DUT
   (
      .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .txTermSel(txTermSel), .rxTermSel(rxTermSel),
      .attenLimitMode(attenLimitMode), .attenPlacement(attenPlacement),
      .attenDepth(attenDepth), .attenBandwidthLow(attenBandwidthLow),
      .txPowerDown(txPowerDown), .lineDriverHighZ(lineDriverHighZ),
      .txDataPolarityLow(txDataPolarityLow), .txSampleRising(txSampleRising),
      .txCodingMode(txCodingMode), .txUseDualRail(txUseDualRail),
      .driverMonitorEnable(driverMonitorEnable),
      .pulseTemplateSel(pulseTemplateSel), .pulseScale(pulseScale)
   );

   // 50 MHz system clock.
   always #10 clk_sys = ~clk_sys;

   // Cycle ceiling; the full sequence needs roughly 1900 cycles.
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         n_errors++;
         report_and_stop;
      end
   end

   // ---------------------------------------------------------------
   // Comparison and verdict tasks
   // ---------------------------------------------------------------
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte

   task automatic cmp_code(input logic [1:0] got, input logic [1:0] exp);
      cmp_byte({6'h00, got}, {6'h00, exp});
   endtask : cmp_code

   task automatic cmp_flag(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask : cmp_flag

   task automatic report_and_stop;
      if (n_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   // ---------------------------------------------------------------
   // Register port tasks; each is entered at a rising edge
   // ---------------------------------------------------------------
   // Signals change by non-blocking assignment at the edge; read data is
   // taken at the next edge, before that edge updates it.
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(posedge clk_sys);
      cmp_byte(regRdData, exp);
   endtask : rd

   function automatic term_type term_exp(input logic [2:0] c);
      return c[2] ? TERM_EXT : (c == 3'h0 ? TERM_INT75 : (c == 3'h1 ? TERM_INT120 : TERM_RSVD));
   endfunction : term_exp

   // Reads every register back and checks every decoded control.
   // Two edges after the write edge the decoded controls have settled.
   task automatic check_all;
      repeat (2) @(posedge clk_sys);
      cmp_code(txTermSel, term_exp(mTerm[5:3]));
      cmp_code(rxTermSel, term_exp(mTerm[2:0]));
      cmp_flag(attenLimitMode, mJa[5]);
      cmp_code(attenPlacement, mJa[4:3] == 2'h1 ? JA_IN_TX :
               (mJa[4:3] == 2'h3 ? JA_IN_RX : JA_UNUSED));
      cmp_code(attenDepth, mJa[2] ? DEPTH_32 : (mJa[1] ? DEPTH_64 : DEPTH_128));
      cmp_flag(attenBandwidthLow, mJa[0]);
      cmp_flag(txPowerDown, mTxa[4]);
      cmp_flag(lineDriverHighZ, mTxa[4] | mTxb[4]);
      cmp_flag(txDataPolarityLow, mTxa[3]);
      cmp_flag(txSampleRising, mTxa[2]);
      cmp_code(txCodingMode, mTxa[1] ? CODE_DUAL_RAIL :
               (mTxa[0] ? CODE_AMI : CODE_HDB3));
      cmp_flag(txUseDualRail, mTxa[1]);
      cmp_flag(driverMonitorEnable, ~mTxb[5]);
      cmp_code(pulseTemplateSel, mTxb[3:0] == 4'h0 ? TPL_E1_75 : (mTxb[3:0] == 4'h1 ?
               TPL_E1_120 : (mTxb[3:2] == 2'h3 ? TPL_USER : TPL_RSVD)));
      cmp_byte({2'h0, pulseScale}, mScale);
      rd(OFS_LINE_IMPEDANCE_MATCH_CFG, mTerm);
      rd(OFS_JITTER_ATTEN_CFG, mJa);
      rd(OFS_TX_PATH_CFG_A, mTxa);
      rd(OFS_TX_PATH_CFG_B, mTxb);
      rd(OFS_TX_PULSE_AMPLITUDE_SCALE, mScale);
   endtask : check_all

   // Writes a register, updates the shadow with the writable bits only.
   task automatic put(input logic [4:0] a, input logic [7:0] d);
      wr(a, d);
      case (a)
         5'h03: mTerm = d & 8'h3F;
         5'h04: mJa = d & 8'h3F;
         5'h05: mTxa = d & 8'h1F;
         5'h06: mTxb = d & 8'h3F;
         5'h07: mScale = d & 8'h3F;
         default: ;
      endcase
      check_all;
   endtask : put

   task automatic do_reset;
      resetn <= 1'b0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      mTerm = 8'h00;
      mJa = 8'h20;
      mTxa = 8'h00;
      mTxb = 8'h10;
      mScale = 8'h21;
      check_all;
   endtask : do_reset

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      logic [3:0] tpl [6] = '{4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF};
      do_reset;
      // Unmapped places swallow writes and read as zero.
      put(5'h08, 8'h5A);
      put(5'h00, 8'hA5);
      rd(5'h1F, 8'h00);
      // Every defined bit of transmit path register A set at once; reserved bits stay at their default.
      put(OFS_TX_PATH_CFG_A, 8'h1F);
      for (int i = 0; i < 8; i++)
         put(OFS_LINE_IMPEDANCE_MATCH_CFG, {2'h0, 3'(i), ~3'(i)});
      for (int i = 0; i < 64; i++)
         put(OFS_JITTER_ATTEN_CFG, 8'(i));
      put(OFS_TX_PATH_CFG_B, 8'h00);
      for (int i = 0; i < 32; i++)
         put(OFS_TX_PATH_CFG_A, 8'(i));
      put(OFS_TX_PATH_CFG_A, 8'h00);
      for (int i = 0; i < 4; i++)
         for (int j = 0; j < 6; j++)
            put(OFS_TX_PATH_CFG_B, {2'h0, 2'(i), tpl[j]});
      // Recommended template for 75 ohm cable under each matching scheme.
      put(OFS_LINE_IMPEDANCE_MATCH_CFG, 8'h00);
      put(OFS_TX_PATH_CFG_B, 8'h00);
      put(OFS_LINE_IMPEDANCE_MATCH_CFG, 8'h24);
      put(OFS_TX_PATH_CFG_B, 8'h01);
      // A reserved template code is accepted but decodes as reserved.
      put(OFS_TX_PATH_CFG_B, 8'h06);
      put(OFS_TX_PULSE_AMPLITUDE_SCALE, 8'h15);
      put(OFS_TX_PULSE_AMPLITUDE_SCALE, 8'h3F);
      // Back-to-back write then reads; read data stands one cycle only.
      wr(OFS_TX_PATH_CFG_A, 8'h0B);
      mTxa = 8'h0B;
      rd(OFS_TX_PATH_CFG_A, 8'h0B);
      rd(OFS_TX_PULSE_AMPLITUDE_SCALE, 8'h3F);
      @(posedge clk_sys);
      cmp_byte(regRdData, 8'h00);
      check_all;
      do_reset;
      report_and_stop;
   end
endmodule : liu_line_and_tx_config_regs_bench
